// *** inc/uevt_pkg.sv ***
package uevt_pkg;
   // register byte offsets on the axi4-lite port
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_IER  = 8'h04;
   localparam logic [7:0] ADDR_IIR  = 8'h08;
   localparam logic [7:0] ADDR_FCR  = 8'h0c;
   localparam logic [7:0] ADDR_LCR  = 8'h10;
   localparam logic [7:0] ADDR_MCR  = 8'h14;
   localparam logic [7:0] ADDR_LSR  = 8'h18;
   localparam logic [7:0] ADDR_MSR  = 8'h1c;
   localparam logic [7:0] ADDR_DLL  = 8'h20;
   localparam logic [7:0] ADDR_DLH  = 8'h24;
   // field positions
   localparam int IER_RX   = 0;
   localparam int IER_THE  = 1;
   localparam int IER_LS   = 2;
   localparam int IER_MS   = 3;
   localparam int FCR_EN   = 0;
   localparam int FCR_DMA  = 3;
   localparam int MCR_RTS  = 1;
   localparam int MCR_AFE  = 5;
   localparam int LSR_DR   = 0;
   localparam int LSR_OE   = 1;
   localparam int LSR_FE   = 3;
   localparam int LSR_THE  = 5;
   localparam int LSR_TEMT = 6;
   // reset values and interrupt ident codes
   localparam logic [15:0] DIV_RST = 16'h0001;
   localparam logic [7:0]  IIR_NONE = 8'h01;
   localparam logic [7:0]  IIR_LS   = 8'h06;
   localparam logic [7:0]  IIR_RX   = 8'h04;
   localparam logic [7:0]  IIR_THE  = 8'h02;
   localparam logic [7:0]  IIR_MS   = 8'h00;
   // baud ticks per bit and transmit timing
   localparam int TICKS_BIT  = 16;
   localparam int TICKS_HALF = 8;
   localparam logic [4:0] TX_START_DLY = 5'd8;   // >= 8 baud cycles before start
   localparam logic [3:0] THE_INT_DLY  = 4'd8;   // 8..10 after start begins
   localparam logic [3:0] TRANSMIT_READY_PIN_DLY    = 4'd8;   // within 9 after start
   localparam logic [4:0] FIFO_DEPTH   = 5'd16;
   typedef enum logic [1:0] {UEVT_TRIG_1, UEVT_TRIG_4, UEVT_TRIG_8, UEVT_TRIG_14} uevt_trig_t;
endpackage

// *** sim/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        I_CLK_SYS, I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_CTS_N, I_DSR_N, I_RX;
   logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_TX, O_RTS_N, O_TRANSMIT_READY_PIN_N, O_RECEIVE_READY_PIN_N, O_INT;
   logic [7:0]  I_AWADDR, I_ARADDR;
   logic [31:0] I_WDATA, O_RDATA, d;
   logic [3:0]  I_WSTRB;
   logic [1:0]  O_BRESP, O_RRESP;
   int          err_count = 0, checked = 0, cyc = 0, tw, t0, n;
   uevt_uart u_dut (.*);
   uevt_remote u_rem (.i_clk(I_CLK_SYS), .o_rx(I_RX));
   initial begin
      I_CLK_SYS = 0;
      forever #2.5 I_CLK_SYS = ~I_CLK_SYS;
   end
   always @(posedge I_CLK_SYS) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo(input logic ok);
      if (!ok) begin
         err_count++;
         $display("[FAIL] %0t bus timeout", $time);
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ga, gw, gb;
      @(posedge I_CLK_SYS);
      I_AWADDR <= a;
      I_WDATA <= v;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      gb = 1'b0;
      for (n = 0; n < 64 && !gb; n++) begin
         @(negedge I_CLK_SYS);
         ga = O_AWREADY;
         gw = O_WREADY && I_WVALID;
         gb = O_BVALID;
         @(posedge I_CLK_SYS);
         if (ga) I_AWVALID <= 1'b0;
         if (gw) I_WVALID <= 1'b0;
         if (gw) tw = cyc + 1;
         if (gb) I_BREADY <= 1'b0;
      end
      @(negedge I_CLK_SYS);
      tmo(gb);
   endtask
   // a fresh edge before each address keeps status reads a cycle behind fifo reads
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ga, gr;
      @(posedge I_CLK_SYS);
      I_ARADDR <= a;
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      gr = 1'b0;
      for (n = 0; n < 64 && !gr; n++) begin
         @(negedge I_CLK_SYS);
         ga = O_ARREADY;
         gr = O_RVALID;
         v = O_RDATA;
         @(posedge I_CLK_SYS);
         if (ga) I_ARVALID <= 1'b0;
         if (gr) I_RREADY <= 1'b0;
      end
      @(negedge I_CLK_SYS);
      tmo(gr);
   endtask
   task automatic t_rst;
      chk({O_TX, O_RTS_N, O_INT, O_RECEIVE_READY_PIN_N}, 4'hd);
      rd(uevt_pkg::ADDR_LSR, d);
      chk(d[7:0], 8'h60);
      rd(uevt_pkg::ADDR_IIR, d);
      chk(d[7:0], uevt_pkg::IIR_NONE);
      rd(8'hfc, d);
      chk(d, 32'h0);
      $display("t_rst done");
   endtask
   task automatic t_tx;
      wr(uevt_pkg::ADDR_IER, 32'h1 << uevt_pkg::IER_THE);
      rd(uevt_pkg::ADDR_IIR, d);
      wr(uevt_pkg::ADDR_DATA, 32'h55);
      chk(O_INT, 1'b0);
      for (n = 0; n < 64 && O_TX; n++) @(negedge I_CLK_SYS);
      t0 = cyc;
      chk(t0 - tw inside {[8:24]}, 1'b1);
      for (n = 0; n < 64 && O_TRANSMIT_READY_PIN_N; n++) @(negedge I_CLK_SYS);
      chk(cyc - t0 <= 9, 1'b1);
      for (n = 0; n < 64 && !O_INT; n++) @(negedge I_CLK_SYS);
      chk(cyc - t0 inside {[8:10]}, 1'b1);
      chk(cyc - tw inside {[16:34]}, 1'b1);
      rd(uevt_pkg::ADDR_IIR, d);
      chk(d[7:0], uevt_pkg::IIR_THE);
      chk(O_INT, 1'b0);
      wr(uevt_pkg::ADDR_IER, 32'h0);
      repeat (200) @(posedge I_CLK_SYS);
      $display("t_tx done");
   endtask
   task automatic t_cts;
      wr(uevt_pkg::ADDR_MCR, 32'h1 << uevt_pkg::MCR_AFE);
      wr(uevt_pkg::ADDR_DATA, 32'h00);
      for (n = 0; n < 64 && O_TRANSMIT_READY_PIN_N; n++) @(negedge I_CLK_SYS);
      wr(uevt_pkg::ADDR_DATA, 32'h00);
      @(posedge I_CLK_SYS) I_CTS_N <= 1'b1;
      repeat (200) @(posedge I_CLK_SYS);
      for (n = 0; n < 200 && O_TX; n++) @(negedge I_CLK_SYS);
      chk(n, 200);
      @(posedge I_CLK_SYS);
      I_CTS_N <= 1'b0;
      t0 = cyc + 1;
      for (n = 0; n < 64 && O_TX; n++) @(negedge I_CLK_SYS);
      chk(cyc - t0 <= 24, 1'b1);
      repeat (200) @(posedge I_CLK_SYS);
      $display("t_cts done");
   endtask
   task automatic t_msr;
      wr(uevt_pkg::ADDR_IER, 32'h1 << uevt_pkg::IER_MS);
      rd(uevt_pkg::ADDR_MSR, d);
      chk(O_INT, 1'b0);
      @(posedge I_CLK_SYS) I_DSR_N <= 1'b0;
      for (n = 0; n < 16 && !O_INT; n++) @(negedge I_CLK_SYS);
      chk(O_INT, 1'b1);
      rd(uevt_pkg::ADDR_MSR, d);
      chk(O_INT, 1'b0);
      wr(uevt_pkg::ADDR_IER, 32'h0);
      $display("t_msr done");
   endtask
   task automatic t_rx;
      wr(uevt_pkg::ADDR_FCR, 32'h1 << uevt_pkg::FCR_EN);
      wr(uevt_pkg::ADDR_MCR, 32'h22);
      wr(uevt_pkg::ADDR_IER, 32'h1 << uevt_pkg::IER_RX);
      chk(O_RTS_N, 1'b0);
      u_rem.send(8'ha5);
      chk({O_INT, O_RECEIVE_READY_PIN_N}, 2'b10);
      chk(O_RTS_N, 1'b1);
      rd(uevt_pkg::ADDR_LSR, d);
      chk(d[uevt_pkg::LSR_DR], 1'b1);
      u_rem.send(8'h3c);
      rd(uevt_pkg::ADDR_LSR, d);
      chk(d[uevt_pkg::LSR_DR], 1'b1);
      rd(uevt_pkg::ADDR_DATA, d);
      chk(d[7:0], 8'ha5);
      chk(O_RTS_N, 1'b1);
      rd(uevt_pkg::ADDR_DATA, d);
      chk(d[7:0], 8'h3c);
      t0 = cyc;
      for (n = 0; n < 16 && O_RTS_N; n++) @(negedge I_CLK_SYS);
      chk(cyc - t0 <= 2, 1'b1);
      $display("t_rx done");
   endtask
   initial begin
      {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_CTS_N} = '0;
      {I_AWADDR, I_ARADDR, I_WDATA} = '0;
      I_WSTRB = 4'hf;
      I_DSR_N = 1'b1;
      I_RST = 1'b1;
      repeat (10) @(posedge I_CLK_SYS);
      I_RST <= 1'b0;
      t_rst();
      t_tx();
      t_cts();
      t_msr();
      t_rx();
      results();
   end
endmodule // tb

// *** sim/uevt_remote.sv ***
module uevt_remote (
   // clock and serial line
   input  wire logic i_clk,
   output logic      o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_rx = 1'b1;
   // 8n1 at 16 clocks a bit; the line idles high between frames
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 160; i++) begin
         @(posedge i_clk);
         o_rx <= f[i/16];
      end
      @(posedge i_clk);
      o_rx <= 1'b1;
   endtask
endmodule // uevt_remote

// *** sim/uevt_uart_props.sv ***
module uevt_uart_props (
   // clock and reset
   input wire logic        I_CLK_SYS,
   input wire logic        I_RST,
   // bus handshakes
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic        O_RVALID,
   input wire logic        I_RREADY,
   input wire logic [31:0] O_RDATA,
   // pins
   input wire logic        I_RX,
   input wire logic        O_TX,
   input wire logic        O_RTS_N,
   input wire logic        O_TRANSMIT_READY_PIN_N,
   input wire logic        O_RECEIVE_READY_PIN_N,
   input wire logic        O_INT
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   // frame trackers hold for divisor 1 only: a data bit falling edge must not pass for a start
   logic [7:0] txf_q, rxf_q;
   logic       txl_q, rxl_q, tx_go, rx_go;
   assign tx_go = txf_q == 8'h00 && txl_q && !O_TX;
   assign rx_go = rxf_q == 8'h00 && rxl_q && !I_RX;
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         txf_q <= 8'h00;
         rxf_q <= 8'h00;
         txl_q <= 1'b1;
         rxl_q <= 1'b1;
      end else begin
         txl_q <= O_TX;
         rxl_q <= I_RX;
         txf_q <= tx_go ? 8'h9f : txf_q - 8'(txf_q != 8'h00);
         rxf_q <= rx_go ? 8'h9f : rxf_q - 8'(rxf_q != 8'h00);
      end
   end
   property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
   property p_b_ans; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> ##1 O_BVALID; endproperty
   a_b_ans: assert property (p_b_ans) else $error("write response late");
   property p_r_ans; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer late");
   property p_rst_pins; $past(I_RST) |-> O_TX && O_RTS_N && !O_INT && !O_BVALID; endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("pins wrong after reset");
   property p_tx_rdy; tx_go |-> ##[0:9] !O_TRANSMIT_READY_PIN_N; endproperty
   a_tx_rdy: assert property (p_tx_rdy) else $error("transmit ready late");
   property p_start_len; tx_go |-> (!O_TX)[*8] ##8 !O_TX; endproperty
   a_start_len: assert property (p_start_len) else $error("start bit too short");
   property p_rx_rdy; rx_go |-> ##[150:160] !O_RECEIVE_READY_PIN_N; endproperty
   a_rx_rdy: assert property (p_rx_rdy) else $error("receive ready late");
endmodule // uevt_uart_props
bind uevt_uart uevt_uart_props u_props (.*);

// *** src/uevt_baud.sv ***
module uevt_baud (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // divisor
   input  wire logic [15:0] i_div,
   // tick
   output logic             o_tick
);
   logic [15:0] cnt_q;

   // a divisor of zero stalls the tick, as a held generator would
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b0;
      end else if (i_div == 16'h0000) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b0;
      end else if (cnt_q >= i_div - 16'h0001) begin
         cnt_q  <= 16'h0000;
         o_tick <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
         o_tick <= 1'b0;
      end
   end
endmodule // uevt_baud

// *** src/uevt_sync.sv ***
module uevt_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // async in, settled out
   input  wire logic [W-1:0] i_async,
   output logic [W-1:0]      o_level
);
   logic [W-1:0] s1_q, s2_q, s3_q;

   // s1 only feeds s2; change counts when s2 and s3 agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q    <= '1;
         s2_q    <= '1;
         s3_q    <= '1;
         o_level <= '1;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int k = 0; k < W; k++) begin
            if (s2_q[k] == s3_q[k]) begin
               o_level[k] <= s3_q[k];
            end
         end
      end
   end
endmodule // uevt_sync

// *** src/uevt_uart.sv ***
// Operation
// - rx interrupt and receive-ready active within one rx tick after stop sample
// - after buffer read, pending receive error raises line-status interrupt within one tick
// - baud cycle comes from reference clock and 16-bit divisor bytes
// - first write to idle transmitter starts start bit 8 to 24 baud cycles later
// - holding-empty interrupt 8 to 10 baud cycles after start bit begins
// - holding-empty interrupt 16 to 34 baud cycles after initial write
// - holding write or ident read clears pending holding-empty interrupt
// - transmit-ready returns active within 9 baud cycles after start bit
// - auto-cts: transmit resumes within 24 baud cycles after cts low
// - cts sampled mid stop bit decides next character
// - auto-rts triggers 1,4,8: rts deasserts within 2 cycles of threshold byte
// - auto-rts triggers 1,4,8: rts reasserts within 2 cycles of last byte read
// - trigger 14: rts deasserts within 2 cycles of 16th character first data bit
// - trigger 14: rts reasserts within 2 cycles of last byte read
// - receive-ready pin mode 1 only when fifo enable and dma select both set; transmit-ready pin has no mode 1
// - first byte into empty fifo sets data-ready; later bytes leave it set
// - modem input change raises enabled interrupt; status read clears it
module uevt_uart (
   // clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   // axi4-lite write
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   output logic [1:0]       O_BRESP,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   // axi4-lite read
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   // serial and modem pins
   input  wire logic        I_RX,
   input  wire logic        I_CTS_N,
   input  wire logic        I_DSR_N,
   output logic             O_TX,
   output logic             O_RTS_N,
   // ready pins and interrupt
   output logic             O_TRANSMIT_READY_PIN_N,
   output logic             O_RECEIVE_READY_PIN_N,
   output logic             O_INT
);
   logic        tick;
   logic        rx_s, cts_n_s, dsr_n_s;
   logic [7:0]  ier_q, fcr_q, lcr_q, mcr_q, dll_q, dlh_q;
   logic [7:0]  rx_mem [16];
   logic [3:0]  rd_ptr_q, wr_ptr_q;
   logic [4:0]  cnt_q;
   logic        oe_q, fe_q, lserr_q, the_int_q, ms_int_q;
   logic [1:0]  msr_d_q;
   logic        dsr_prev_q, cts_prev_q;
   logic        aw_q, w_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wr_go, rd_go, rd_data, wr_data, rd_iir, rd_msr, rd_lsr;
   logic        fifo_mode, mode1, rts_block;

   uevt_sync #(.W(3)) u_sync (
      .i_clk   (I_CLK_SYS),
      .i_rst   (I_RST),
      .i_async ({I_RX, I_CTS_N, I_DSR_N}),
      .o_level ({rx_s, cts_n_s, dsr_n_s})
   );

   uevt_baud u_baud (
      .i_clk  (I_CLK_SYS),
      .i_rst  (I_RST),
      .i_div  ({dlh_q, dll_q}),
      .o_tick (tick)
   );

   assign fifo_mode = fcr_q[uevt_pkg::FCR_EN];
   assign mode1     = fcr_q[uevt_pkg::FCR_EN] & fcr_q[uevt_pkg::FCR_DMA];

   // ---------------- axi4-lite slave ----------------
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         O_BVALID  <= 1'b0;
         O_AWREADY <= 1'b1;
         O_WREADY  <= 1'b1;
      end else begin
         if (I_AWVALID && O_AWREADY) begin
            aw_q      <= 1'b1;
            awaddr_q  <= I_AWADDR;
            O_AWREADY <= 1'b0;
         end
         if (I_WVALID && O_WREADY) begin
            w_q      <= 1'b1;
            wdata_q  <= I_WSTRB[0] ? I_WDATA : 32'h0000_0000;
            O_WREADY <= 1'b0;
         end
         if (wr_go) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            O_BVALID <= 1'b1;
         end else if (O_BVALID && I_BREADY) begin
            O_BVALID  <= 1'b0;
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
         end
      end
   end
   assign O_BRESP   = 2'b00;
   assign wr_go     = aw_q & w_q & ~O_BVALID;
   assign rd_go     = I_ARVALID & O_ARREADY;
   assign wr_data   = wr_go && awaddr_q == uevt_pkg::ADDR_DATA && !lcr_q[7];
   assign rd_data   = rd_go && I_ARADDR == uevt_pkg::ADDR_DATA && !lcr_q[7];
   assign rd_iir    = rd_go && I_ARADDR == uevt_pkg::ADDR_IIR;
   assign rd_lsr    = rd_go && I_ARADDR == uevt_pkg::ADDR_LSR;
   assign rd_msr    = rd_go && I_ARADDR == uevt_pkg::ADDR_MSR;

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         ier_q <= 8'h00;
         fcr_q <= 8'h00;
         lcr_q <= 8'h00;
         mcr_q <= 8'h00;
         dll_q <= uevt_pkg::DIV_RST[7:0];
         dlh_q <= uevt_pkg::DIV_RST[15:8];
      end else if (wr_go) begin
         unique case (awaddr_q)
            uevt_pkg::ADDR_DATA: if (lcr_q[7]) dll_q <= wdata_q[7:0];
            uevt_pkg::ADDR_IER:  if (lcr_q[7]) dlh_q <= wdata_q[7:0]; else ier_q <= {4'h0, wdata_q[3:0]};
            uevt_pkg::ADDR_FCR:  fcr_q <= wdata_q[7:0];
            uevt_pkg::ADDR_LCR:  lcr_q <= wdata_q[7:0];
            uevt_pkg::ADDR_MCR:  mcr_q <= {2'b00, wdata_q[5:0]};
            uevt_pkg::ADDR_DLL:  dll_q <= wdata_q[7:0];
            uevt_pkg::ADDR_DLH:  dlh_q <= wdata_q[7:0];
            default: ;
         endcase
      end
   end

   // ---------------- transmitter ----------------
   typedef enum logic [2:0] {UEVT_IDLE, UEVT_WAIT, UEVT_START, UEVT_DATA, UEVT_STOP} uevt_tx_t;
   uevt_tx_t    tx_st_q;
   logic [7:0]  thr_q, tsr_q;
   logic        thr_full_q;
   logic [4:0]  tx_tick_q;
   logic [2:0]  tx_bit_q;
   logic        cts_hold_q;

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         tx_st_q    <= UEVT_IDLE;
         thr_q      <= 8'h00;
         tsr_q      <= 8'h00;
         thr_full_q <= 1'b0;
         tx_tick_q  <= 5'd0;
         tx_bit_q   <= 3'd0;
         cts_hold_q <= 1'b0;
         O_TX       <= 1'b1;
      end else begin
         if (wr_data) begin
            thr_q      <= wdata_q[7:0];
            thr_full_q <= 1'b1;
         end
         if (tick) begin
            unique case (tx_st_q)
               UEVT_IDLE: begin
                  tx_tick_q <= 5'd0;
                  if (thr_full_q && !cts_hold_q) tx_st_q <= UEVT_WAIT;
                  else if (cts_hold_q && cts_n_s == 1'b0) cts_hold_q <= 1'b0;
               end
               UEVT_WAIT: begin
                  tx_tick_q <= tx_tick_q + 5'd1;
                  if (tx_tick_q == uevt_pkg::TX_START_DLY - 5'd1) begin
                     tx_st_q    <= UEVT_START;
                     tsr_q      <= thr_q;
                     thr_full_q <= wr_data;
                     tx_tick_q  <= 5'd0;
                     O_TX       <= 1'b0;
                  end
               end
               UEVT_START, UEVT_DATA: begin
                  tx_tick_q <= tx_tick_q + 5'd1;
                  if (tx_tick_q == 5'(uevt_pkg::TICKS_BIT - 1)) begin
                     tx_tick_q <= 5'd0;
                     if (tx_st_q == UEVT_START) begin
                        tx_st_q  <= UEVT_DATA;
                        tx_bit_q <= 3'd0;
                        O_TX     <= tsr_q[0];
                     end else if (tx_bit_q == 3'd7) begin
                        tx_st_q <= UEVT_STOP;
                        O_TX    <= 1'b1;
                     end else begin
                        tx_bit_q <= tx_bit_q + 3'd1;
                        O_TX     <= tsr_q[3'(tx_bit_q + 3'd1)];
                     end
                  end
               end
               UEVT_STOP: begin
                  tx_tick_q <= tx_tick_q + 5'd1;
                  // cts checked at stop midpoint gates the next character
                  if (tx_tick_q == 5'(uevt_pkg::TICKS_HALF)) begin
                     cts_hold_q <= mcr_q[uevt_pkg::MCR_AFE] & cts_n_s;
                  end
                  if (tx_tick_q == 5'(uevt_pkg::TICKS_BIT - 1)) begin
                     tx_st_q   <= UEVT_IDLE;
                     tx_tick_q <= 5'd0;
                  end
               end
               default: tx_st_q <= UEVT_IDLE;
            endcase
         end
      end
   end

   // holding-empty interrupt: set 8 ticks into the start bit, clear by write or ident read
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         the_int_q <= 1'b0;
         O_TRANSMIT_READY_PIN_N <= 1'b0;
      end else begin
         if (tick && tx_st_q == UEVT_START && tx_tick_q[3:0] == uevt_pkg::THE_INT_DLY - 4'd1 && !thr_full_q)
            the_int_q <= 1'b1;
         else if (wr_data || rd_iir)
            the_int_q <= 1'b0;
         if (wr_data)
            O_TRANSMIT_READY_PIN_N <= 1'b1;
         else if (tick && tx_st_q == UEVT_START && tx_tick_q[3:0] == uevt_pkg::TRANSMIT_READY_PIN_DLY - 4'd1)
            O_TRANSMIT_READY_PIN_N <= thr_full_q;
      end
   end

   // ---------------- receiver ----------------
   typedef enum logic [1:0] {UEVT_RIDLE, UEVT_RSTART, UEVT_RDATA, UEVT_RSTOP} uevt_rx_t;
   uevt_rx_t   rx_st_q;
   logic [4:0] rx_tick_q;
   logic [2:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic       push;
   logic [4:0] trig_lvl;

   always_comb begin
      unique case (uevt_pkg::uevt_trig_t'(fcr_q[7:6]))
         uevt_pkg::UEVT_TRIG_1: trig_lvl = 5'd1;
         uevt_pkg::UEVT_TRIG_4: trig_lvl = 5'd4;
         uevt_pkg::UEVT_TRIG_8: trig_lvl = 5'd8;
         uevt_pkg::UEVT_TRIG_14: trig_lvl = 5'd14;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         rx_st_q   <= UEVT_RIDLE;
         rx_tick_q <= 5'd0;
         rx_bit_q  <= 3'd0;
         rx_sh_q   <= 8'h00;
         push      <= 1'b0;
         fe_q      <= 1'b0;
      end else begin
         push <= 1'b0;
         if (tick) begin
            rx_tick_q <= rx_tick_q + 5'd1;
            unique case (rx_st_q)
               UEVT_RIDLE: begin
                  rx_tick_q <= 5'd0;
                  if (!rx_s) rx_st_q <= UEVT_RSTART;
               end
               UEVT_RSTART: if (rx_tick_q == 5'(uevt_pkg::TICKS_HALF - 1)) begin
                  rx_tick_q <= 5'd0;
                  rx_bit_q  <= 3'd0;
                  rx_st_q   <= rx_s ? UEVT_RIDLE : UEVT_RDATA; // false start rejected
               end
               UEVT_RDATA: if (rx_tick_q == 5'(uevt_pkg::TICKS_BIT - 1)) begin
                  rx_tick_q <= 5'd0;
                  rx_sh_q   <= {rx_s, rx_sh_q[7:1]};
                  rx_bit_q  <= rx_bit_q + 3'd1;
                  if (rx_bit_q == 3'd7) rx_st_q <= UEVT_RSTOP;
               end
               UEVT_RSTOP: if (rx_tick_q == 5'(uevt_pkg::TICKS_BIT - 1)) begin
                  push    <= 1'b1;
                  fe_q    <= ~rx_s;
                  rx_st_q <= UEVT_RIDLE;
               end
            endcase
         end
      end
   end

   // fifo storage and flags; a same-cycle push and pop leave the count unchanged
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         rd_ptr_q  <= 4'h0;
         wr_ptr_q  <= 4'h0;
         cnt_q     <= 5'd0;
         oe_q      <= 1'b0;
         lserr_q   <= 1'b0;
      end else begin
         if (push && (cnt_q < (fifo_mode ? uevt_pkg::FIFO_DEPTH : 5'd1) || (rd_data && cnt_q != 5'd0))) begin
            rx_mem[wr_ptr_q] <= rx_sh_q;
            wr_ptr_q         <= wr_ptr_q + 4'h1;
         end
         if (push && !(rd_data && cnt_q != 5'd0) && cnt_q < (fifo_mode ? uevt_pkg::FIFO_DEPTH : 5'd1))
            cnt_q <= cnt_q + 5'd1;
         else if (!push && rd_data && cnt_q != 5'd0)
            cnt_q <= cnt_q - 5'd1;
         if (rd_data && cnt_q != 5'd0) rd_ptr_q <= rd_ptr_q + 4'h1;
         if (push && cnt_q == (fifo_mode ? uevt_pkg::FIFO_DEPTH : 5'd1) && !rd_data) oe_q <= 1'b1;
         else if (rd_lsr) oe_q <= 1'b0;
         // pending error surfaces once the buffer read lands
         if (rd_data && (fe_q || oe_q)) lserr_q <= 1'b1;
         else if (rd_lsr) lserr_q <= 1'b0;
      end
   end

   // auto-rts: block at threshold (or 16th char at level 14), release when empty
   assign rts_block = (trig_lvl == 5'd14) ?
                      (rx_st_q == UEVT_RDATA && cnt_q >= 5'd15) || cnt_q >= uevt_pkg::FIFO_DEPTH :
                      (cnt_q >= trig_lvl);
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         O_RTS_N <= 1'b1;
      end else if (mcr_q[uevt_pkg::MCR_AFE] && fifo_mode) begin
         if (rts_block) O_RTS_N <= 1'b1;
         else if (cnt_q == 5'd0) O_RTS_N <= ~mcr_q[uevt_pkg::MCR_RTS];
      end else begin
         O_RTS_N <= ~mcr_q[uevt_pkg::MCR_RTS];
      end
   end

   // receive-ready pin: mode 0 on any byte, mode 1 on trigger level
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) O_RECEIVE_READY_PIN_N <= 1'b1;
      else O_RECEIVE_READY_PIN_N <= mode1 ? (cnt_q + {4'h0, push} < trig_lvl) : (cnt_q == 5'd0 && !push);
   end

   // modem status change
   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         cts_prev_q <= 1'b1;
         dsr_prev_q <= 1'b1;
         msr_d_q    <= 2'b00;
         ms_int_q   <= 1'b0;
      end else begin
         cts_prev_q <= cts_n_s;
         dsr_prev_q <= dsr_n_s;
         if (cts_prev_q != cts_n_s || dsr_prev_q != dsr_n_s) begin
            msr_d_q  <= msr_d_q | {dsr_prev_q != dsr_n_s, cts_prev_q != cts_n_s};
            ms_int_q <= 1'b1;
         end else if (rd_msr) begin
            msr_d_q  <= 2'b00;
            ms_int_q <= 1'b0;
         end
      end
   end

   // ---------------- read path and interrupt ----------------
   function automatic logic [7:0] uevt_iir(input logic [7:0] ier, input logic ls, input logic rx,
                                           input logic th, input logic ms);
      if (ier[uevt_pkg::IER_LS] && ls)       uevt_iir = uevt_pkg::IIR_LS;
      else if (ier[uevt_pkg::IER_RX] && rx)  uevt_iir = uevt_pkg::IIR_RX;
      else if (ier[uevt_pkg::IER_THE] && th) uevt_iir = uevt_pkg::IIR_THE;
      else if (ier[uevt_pkg::IER_MS] && ms)  uevt_iir = uevt_pkg::IIR_MS;
      else                                   uevt_iir = uevt_pkg::IIR_NONE;
   endfunction

   logic [7:0] iir_now;
   logic       rx_avail;
   assign rx_avail = fifo_mode ? (cnt_q + {4'h0, push} >= trig_lvl) : (cnt_q != 5'd0 || push);
   assign iir_now  = uevt_iir(ier_q, lserr_q, rx_avail, the_int_q, ms_int_q);

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         O_RVALID  <= 1'b0;
         O_RDATA   <= 32'h0000_0000;
         O_INT     <= 1'b0;
         O_ARREADY <= 1'b1;
      end else begin
         O_INT <= ~iir_now[0];
         if (rd_go) begin
            O_RVALID  <= 1'b1;
            O_ARREADY <= 1'b0;
            unique case (I_ARADDR)
               uevt_pkg::ADDR_DATA: O_RDATA <= {24'h0, lcr_q[7] ? dll_q : rx_mem[rd_ptr_q]};
               uevt_pkg::ADDR_IER:  O_RDATA <= {24'h0, lcr_q[7] ? dlh_q : ier_q};
               uevt_pkg::ADDR_IIR:  O_RDATA <= {24'h0, fifo_mode ? 2'b11 : 2'b00, iir_now[5:0]};
               uevt_pkg::ADDR_LCR:  O_RDATA <= {24'h0, lcr_q};
               uevt_pkg::ADDR_MCR:  O_RDATA <= {24'h0, mcr_q};
               uevt_pkg::ADDR_LSR:  O_RDATA <= {24'h0, 1'b0, tx_st_q == UEVT_IDLE && !thr_full_q, !thr_full_q,
                                                2'b00, fe_q, oe_q, cnt_q != 5'd0};
               uevt_pkg::ADDR_MSR:  O_RDATA <= {24'h0, 2'b00, ~dsr_n_s, ~cts_n_s, 2'b00, msr_d_q};
               uevt_pkg::ADDR_DLL:  O_RDATA <= {24'h0, dll_q};
               uevt_pkg::ADDR_DLH:  O_RDATA <= {24'h0, dlh_q};
               default:             O_RDATA <= 32'h0000_0000;
            endcase
         end else if (O_RVALID && I_RREADY) begin
            O_RVALID  <= 1'b0;
            O_ARREADY <= 1'b1;
         end
      end
   end
   assign O_RRESP = 2'b00;
endmodule // uevt_uart
